/* File: auto_seq_defs.svh */
// Constants for the stage-sequence controller: terminal function codes, widths, timing.
// Assumes a 200 MHz system clock. Every time base is derived from the 10 ms tick.
`ifndef AUTO_SEQ_DEFS_SVH
`define AUTO_SEQ_DEFS_SVH

`define CODE_SEQ1 6'h29
`define CODE_SEQ2 6'h2a
`define CODE_MANUAL 6'h2b
`define CODE_GO_STEP 6'h2c
`define CODE_HOLD_STEP 6'h2d
`define CODE_STEP_PULSE 6'h14
`define CODE_SEQ_PULSE 6'h15
`define APP_AUTO_SEQUENCE 3'h4
`define AUTO_MODE_FREE 1'h0
`define AUTO_MODE_STEPPED 1'h1

`define FUNC_W 6
`define FREQ_W 16
`define TIME_W 13
`define CNT_W 16
`define TICK_W 24
`define STAGE_W 3
`define MAX_STAGES 8
`define ENTRY_W 43

`define CLK_FREQ_MHZ 200
`define TICK_TIME_US 10000
`define TICK_CYCLES (`TICK_TIME_US * `CLK_FREQ_MHZ)
`define PULSE_TIME_MS 100
`define PULSE_TICKS (`PULSE_TIME_MS * 1000 / `TICK_TIME_US)
`define TENTH_SEC_TICKS (100000 / `TICK_TIME_US)

`endif

/* File: auto_seq_pkg.sv */
// Types for the stage-sequence controller: state encoding and the state record.
// Assumes auto_seq_defs.svh is on the include path.
`include "auto_seq_defs.svh"

package auto_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_LOAD = 3'h2,
    ST_RAMP = 3'h3,
    ST_DWELL = 3'h4,
    ST_WAIT_GO = 3'h5,
    ST_DONE = 3'h6,
    ST_BLOCKED = 3'h7
  } seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic prog;
    logic [`STAGE_W-1:0] stage;
    logic [`TICK_W-1:0] tick_cnt;
    logic [`CNT_W-1:0] time_cnt;
    logic [3:0] step_pulse_cnt;
    logic [3:0] seq_pulse_cnt;
    logic [`TIME_W-1:0] ramp_time;
    logic [`TIME_W-1:0] dwell_time;
    logic go_prev;
    logic run;
    logic forward;
    logic manual;
    logic ramping;
    logic [`FREQ_W-1:0] target_freq;
    logic [2:0] aux_out;
  } seq_regs_t;

endpackage

/* File: stage_table_mem.sv */
// Stage settings table: speed, ramp time, dwell time and sense per program and stage.
// Assumes one writer on the system clock; read data appear one edge after the address.
`timescale 1ns/100ps
`include "auto_seq_defs.svh"

module stage_table_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = `ENTRY_W
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  // An address needs at least one bit, so a single-entry table is refused.
  if (DEPTH < 2 || WIDTH < 1) begin : g_param_check
    $error("stage_table_mem: parameter out of range");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array so it maps onto block memory; software loads it before use.
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

/* File: auto_seq_ctrl.sv */
// Stage-sequence controller: runs one of two stage programs from terminal inputs.
// Assumes terminals and function selects are static pins; settings are loaded beforehand.
//
// Overview of operation
// - Terminal coded 41 starts program one, coded 42 starts program two.
// - Terminal coded 43 hands the drive to the ordinary command and speed sources.
// - Stepped mode: terminal coded 44 while stopped starts the next stage.
// - Free mode: terminal coded 45 held freezes the current stage.
// - Output coded 20 pulses for 100 ms at every stage change.
// - Output coded 21 pulses when the program reaches its final stage.
// - Free mode runs all stages in order after one program select.
// - Stepped mode: select held by the far side, one stage per advance.
// - Second select within the coincidence time counts as simultaneous.
// - Exactly the configured stage count, clamped to 1..8, is executed per program.
// - Each stage has its own speed; a program starts at stage one's.
// - Stage ramp time sets how long reaching the target speed takes.
// - After the ramp, each stage holds speed for its dwell time.
// - Each stage drives its configured rotation sense.
// - At most two programs are available.
// - Function works only when application selection equals 4.
// - Up to eight stages per program, each fully configurable.
`timescale 1ns/100ps
`include "auto_seq_defs.svh"

module auto_seq_ctrl
  import auto_seq_pkg::*;
#(
  parameter int NUM_TERM = 8,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [NUM_TERM-1:0] term_i,
  input wire logic [NUM_TERM*`FUNC_W-1:0] input_function_select_i,
  input wire logic [3*`FUNC_W-1:0] output_function_select_i,
  input wire logic [2:0] app_mode_i,
  input wire logic auto_mode_i,
  input wire logic [7:0] auto_check_i,
  input wire logic [3:0] step_count1_i,
  input wire logic [3:0] step_count2_i,
  input wire logic cfg_we_i,
  input wire logic cfg_prog_i,
  input wire logic [`STAGE_W-1:0] cfg_stage_i,
  input wire logic [`FREQ_W-1:0] cfg_freq_i,
  input wire logic [`TIME_W-1:0] cfg_ramp_i,
  input wire logic [`TIME_W-1:0] cfg_dwell_i,
  input wire logic cfg_forward_i,
  output logic run_o,
  output logic forward_o,
  output logic manual_o,
  output logic ramping_o,
  output logic [`FREQ_W-1:0] target_freq_o,
  output logic [`TIME_W-1:0] ramp_time_o,
  output logic prog_o,
  output logic [`STAGE_W-1:0] stage_o,
  output logic [2:0] aux_out_o
);

  if (NUM_TERM < 1 || NUM_TERM > 11 || TICK_CYCLES < 2 ||
      TICK_CYCLES >= (1 << `TICK_W)) begin : g_param_check
    $error("auto_seq_ctrl: parameter out of range");
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Terminal synchronisers and stage table.

  logic [NUM_TERM-1:0] term_meta_reg;
  logic [NUM_TERM-1:0] term_sync_reg;
  seq_regs_t r_reg;
  seq_regs_t r_next;
  logic [`ENTRY_W-1:0] entry;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_meta_reg <= '0;
      term_sync_reg <= '0;
    end else begin
      term_meta_reg <= term_i;
      term_sync_reg <= term_meta_reg;
    end
  end

  // Two programs of eight stages share one table, addressed {program, stage}.
  stage_table_mem #(
    .DEPTH(2 * `MAX_STAGES),
    .WIDTH(`ENTRY_W)
  ) u_table (
    .clk_sys_i(clk_sys_i),
    .we_i(cfg_we_i),
    .waddr_i({cfg_prog_i, cfg_stage_i}),
    .wdata_i({cfg_freq_i, cfg_ramp_i, cfg_dwell_i, cfg_forward_i}),
    .raddr_i({r_next.prog, r_next.stage}),
    .rdata_o(entry)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic seq1;
  logic seq2;
  logic manual;
  logic go;
  logic hold;
  logic tick;
  logic sel_held;
  logic enabled;
  logic stepped;
  logic [`STAGE_W-1:0] last_stage;
  logic [3:0] count;

  always_comb begin
    seq1 = 1'b0;
    seq2 = 1'b0;
    manual = 1'b0;
    go = 1'b0;
    hold = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      if (term_sync_reg[t]) begin
        seq1 = seq1 | (input_function_select_i[t*`FUNC_W +: `FUNC_W] == `CODE_SEQ1);
        seq2 = seq2 | (input_function_select_i[t*`FUNC_W +: `FUNC_W] == `CODE_SEQ2);
        manual = manual | (input_function_select_i[t*`FUNC_W +: `FUNC_W] == `CODE_MANUAL);
        go = go | (input_function_select_i[t*`FUNC_W +: `FUNC_W] == `CODE_GO_STEP);
        hold = hold | (input_function_select_i[t*`FUNC_W +: `FUNC_W] == `CODE_HOLD_STEP);
      end
    end
    tick = (r_reg.tick_cnt == `TICK_W'(TICK_CYCLES - 1));
    stepped = (auto_mode_i == `AUTO_MODE_STEPPED);
    enabled = (app_mode_i == `APP_AUTO_SEQUENCE) && !manual;
    sel_held = r_reg.prog ? seq2 : seq1;
    count = r_reg.prog ? step_count2_i : step_count1_i;
    // A count of zero is treated as one stage; counts above eight are clamped.
    last_stage = (count == 4'h0) ? 3'h0 : (count > 4'h8) ? 3'h7 : 3'(count - 4'h1);

    r_next = r_reg;
    r_next.go_prev = go;
    r_next.tick_cnt = tick ? '0 : r_reg.tick_cnt + `TICK_W'(1);
    r_next.manual = manual && (app_mode_i == `APP_AUTO_SEQUENCE);
    if (tick && r_reg.step_pulse_cnt != 4'h0) begin
      r_next.step_pulse_cnt = r_reg.step_pulse_cnt - 4'h1;
    end
    if (tick && r_reg.seq_pulse_cnt != 4'h0) begin
      r_next.seq_pulse_cnt = r_reg.seq_pulse_cnt - 4'h1;
    end

    case (r_reg.state)
      ST_IDLE: begin
        r_next.run = 1'b0;
        r_next.ramping = 1'b0;
        if (seq1 && seq2) begin
          r_next.state = ST_BLOCKED;
        end else if (seq1 || seq2) begin
          r_next.state = ST_CHECK;
          r_next.prog = seq2;
          r_next.time_cnt = '0;
        end
      end
      ST_CHECK: begin
        // The coincidence window is counted in 10 ms ticks, so it may run one tick short.
        if (seq1 && seq2) begin
          r_next.state = ST_BLOCKED;
        end else if (!sel_held) begin
          r_next.state = ST_IDLE;
        end else if (r_reg.time_cnt >= `CNT_W'(auto_check_i)) begin
          r_next.stage = '0;
          r_next.state = stepped ? ST_WAIT_GO : ST_LOAD;
        end else if (tick) begin
          r_next.time_cnt = r_reg.time_cnt + `CNT_W'(1);
        end
      end
      ST_LOAD: begin
        r_next.target_freq = entry[`ENTRY_W-1 -: `FREQ_W];
        r_next.ramp_time = entry[2*`TIME_W:`TIME_W+1];
        r_next.dwell_time = entry[`TIME_W:1];
        r_next.forward = entry[0];
        r_next.run = 1'b1;
        r_next.ramping = 1'b1;
        r_next.time_cnt = '0;
        r_next.step_pulse_cnt = 4'(`PULSE_TICKS + 1);
        if (r_reg.stage == last_stage) begin
          r_next.seq_pulse_cnt = 4'(`PULSE_TICKS + 1);
        end
        r_next.state = ST_RAMP;
      end
      ST_RAMP, ST_DWELL: begin
        if (stepped && !sel_held) begin
          r_next.state = ST_IDLE;
        end else if (tick && !(hold && !stepped)) begin
          r_next.time_cnt = r_reg.time_cnt + `CNT_W'(1);
          if (r_reg.state == ST_RAMP) begin
            if (r_next.time_cnt >= `CNT_W'(r_reg.ramp_time * `TENTH_SEC_TICKS)) begin
              r_next.state = ST_DWELL;
              r_next.ramping = 1'b0;
              r_next.time_cnt = '0;
            end
          end else if (r_next.time_cnt >= `CNT_W'(r_reg.dwell_time * `TENTH_SEC_TICKS)) begin
            if (r_reg.stage == last_stage) begin
              r_next.state = ST_DONE;
              r_next.run = 1'b0;
            end else begin
              r_next.stage = r_reg.stage + 3'h1;
              r_next.state = stepped ? ST_WAIT_GO : ST_LOAD;
              r_next.run = !stepped;
            end
          end
        end
      end
      ST_WAIT_GO: begin
        r_next.run = 1'b0;
        if (!sel_held) begin
          r_next.state = ST_IDLE;
        end else if (go && !r_reg.go_prev) begin
          r_next.state = ST_LOAD;
        end
      end
      ST_DONE, ST_BLOCKED: begin
        // Waiting for release stops a held select from restarting the program at once.
        r_next.run = 1'b0;
        if (!seq1 && !seq2) begin
          r_next.state = ST_IDLE;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    if (!enabled) begin
      r_next.state = ST_IDLE;
      r_next.run = 1'b0;
      r_next.ramping = 1'b0;
    end

    for (int k = 0; k < 3; k++) begin
      case (output_function_select_i[k*`FUNC_W +: `FUNC_W])
        `CODE_STEP_PULSE: r_next.aux_out[k] = (r_next.step_pulse_cnt != 4'h0);
        `CODE_SEQ_PULSE: r_next.aux_out[k] = (r_next.seq_pulse_cnt != 4'h0);
        default: r_next.aux_out[k] = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{state: ST_IDLE, forward: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign run_o = r_reg.run;
  assign forward_o = r_reg.forward;
  assign manual_o = r_reg.manual;
  assign ramping_o = r_reg.ramping;
  assign target_freq_o = r_reg.target_freq;
  assign ramp_time_o = r_reg.ramp_time;
  assign prog_o = r_reg.prog;
  assign stage_o = r_reg.stage;
  assign aux_out_o = r_reg.aux_out;

endmodule

/* File: auto_seq_ctrl_sva.sv */
// Port assertions for the stage-sequence controller.
// Assumes terminals 0..4 carry codes 41..45, aux outputs 0 and 1 codes 20 and 21.
`timescale 1ns/100ps
module auto_seq_sva #(
  parameter int NUM_TERM = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [NUM_TERM-1:0] term_i,
  input wire logic [2:0] app_mode_i,
  input wire logic auto_mode_i,
  input wire logic [3:0] step_count1_i,
  input wire logic run_o,
  input wire logic manual_o,
  input wire logic prog_o,
  input wire logic [2:0] stage_o,
  input wire logic [2:0] aux_out_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////
  sequence load_s;
    $rose(run_o) || (run_o && $changed(stage_o));
  endsequence
  sequence last_s;
    load_s ##0 (!prog_o && {1'b0, stage_o} == step_count1_i - 4'h1);
  endsequence
  chk_step_pulse: assert property (load_s |-> ##[1:3] aux_out_o[0])
    else $error("no step pulse");
  chk_last_pulse: assert property (last_s |-> ##[1:3] aux_out_o[1])
    else $error("no last pulse");
  chk_stage_order: assert property (
    run_o && $past(run_o) && $changed(stage_o) |-> stage_o == $past(stage_o) + 3'h1)
    else $error("stage skipped");
  chk_stage_bound: assert property (
    run_o && !prog_o && step_count1_i inside {[4'h1:4'h8]} |-> {1'b0, stage_o} < step_count1_i)
    else $error("stage past count");
  chk_freeze_hold: assert property (
    (!auto_mode_i && term_i[4] && run_o)[*5] |-> $stable(stage_o))
    else $error("stage moved in freeze");
  chk_both_blocked: assert property (
    (term_i[0] && term_i[1] && !run_o && !auto_mode_i)[*4] |=> !run_o)
    else $error("start with both selects");
  chk_manual_stop: assert property (manual_o |=> !run_o)
    else $error("run in manual");
  chk_app_gate: assert property (app_mode_i != 3'h4 |=> !run_o && !manual_o)
    else $error("active outside mode 4");
endmodule
bind auto_seq_ctrl auto_seq_sva #(.NUM_TERM(NUM_TERM)) sva_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .term_i(term_i), .app_mode_i(app_mode_i),
  .auto_mode_i(auto_mode_i), .step_count1_i(step_count1_i), .run_o(run_o),
  .manual_o(manual_o), .prog_o(prog_o), .stage_o(stage_o), .aux_out_o(aux_out_o));

/* File: term_panel.sv */
// Terminal panel: switch contacts that the bench opens and closes.
// Assumes the bench changes the wanted contacts just after a rising edge.
`timescale 1ns/100ps
module term_panel (
  input wire logic clk_sys_i,
  input wire logic [4:0] want_i,
  output logic [7:0] term_o
);
  // Unused terminals have pull-downs, so they read low rather than floating.
  always @(posedge clk_sys_i) begin
    term_o <= {3'h0, want_i};
  end
endmodule

/* File: tb_auto_sequence_controller.sv */
// Bench for the stage-sequence controller, driving its terminals through the panel model.
// Assumes the tick is cut to 4 cycles so stage times stay short.
`timescale 1ns/100ps
module tb_auto_sequence_controller;
  localparam int TK = 4;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] want = 5'h00;
  logic [7:0] term;
  logic [2:0] app_mode = 3'h4;
  logic auto_mode = 1'b0;
  logic we = 1'b0;
  logic wprog = 1'b0;
  logic [2:0] wstage = 3'h0;
  logic [15:0] wfreq = 16'h0000;
  logic [12:0] wtime = 13'h0001;
  logic wfwd = 1'b0;
  logic run, fwd, man, rmp, prog;
  logic [15:0] freq;
  logic [12:0] rt;
  logic [2:0] stg, aux;
  int n_mismatch = 0;
  int comparisons = 0;
  int width = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  term_panel panel_u (.clk_sys_i(clk_sys_i), .want_i(want), .term_o(term));
  auto_seq_ctrl #(.TICK_CYCLES(TK)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .term_i(term),
    .input_function_select_i({18'h0, 6'h2d, 6'h2c, 6'h2b, 6'h2a, 6'h29}),
    .output_function_select_i({6'h00, 6'h15, 6'h14}), .app_mode_i(app_mode),
    .auto_mode_i(auto_mode), .auto_check_i(8'h04), .step_count1_i(4'h3),
    .step_count2_i(4'h2), .cfg_we_i(we), .cfg_prog_i(wprog), .cfg_stage_i(wstage),
    .cfg_freq_i(wfreq), .cfg_ramp_i(wtime), .cfg_dwell_i(wtime), .cfg_forward_i(wfwd),
    .run_o(run), .forward_o(fwd), .manual_o(man), .ramping_o(rmp), .target_freq_o(freq),
    .ramp_time_o(rt), .prog_o(prog), .stage_o(stg), .aux_out_o(aux));
  ////////////////////////////////
  function automatic logic [15:0] efreq(input logic p, input logic [2:0] s);
    return {4'h1, 3'h0, p, 5'h00, s};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic set(input int b, input logic v);
    @(posedge clk_sys_i);
    want[b] <= v;
  endtask
  task automatic wait_run(input logic v);
    int k;
    k = 0;
    while (run !== v && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("run", 16'(v), 16'(run));
  endtask
  task automatic go();
    set(3, 1'b1);
    cyc(4);
    set(3, 1'b0);
  endtask
  task automatic stage_seen(input logic p, input logic [2:0] s, input logic last);
    int k;
    k = 0;
    while (!(run === 1'b1 && stg === s) && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    cyc(2);
    chk("stage", 16'(s), 16'(stg));
    chk("program", 16'(p), 16'(prog));
    chk("speed", efreq(p, s), freq);
    chk("sense", 16'(s[0]), 16'(fwd));
    chk("ramp time", 16'h0001, 16'(rt));
    chk("ramping", 16'h0001, 16'(rmp));
    cyc(3);
    chk("last pulse", 16'(last), 16'(aux[1]));
    chk("spare output", 16'h0, 16'(aux[2]));
    k = 0;
    while (rmp === 1'b1 && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("ramp length", 16'h1, 16'(k >= 9 * TK - 5 && k <= 10 * TK - 4));
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////
  // The whole sequence needs about 1000 cycles; twenty times that means a hang.
  initial begin
    #(5.0 * 20000);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      we <= 1'b1;
      wprog <= i[3];
      wstage <= i[2:0];
      wfreq <= efreq(i[3], i[2:0]);
      wfwd <= i[0];
    end
    @(posedge clk_sys_i);
    we <= 1'b0;
    set(0, 1'b1);
    wait_run(1'b1);
    fork
      stage_seen(1'b0, 3'h0, 1'b0);
      repeat (60) begin
        @(negedge clk_sys_i);
        if (aux[0] === 1'b1) width++;
      end
    join
    chk("pulse width ok", 16'h1, 16'(width >= 10 * TK && width <= 11 * TK));
    set(4, 1'b1);
    set(0, 1'b0);
    cyc(200);
    chk("held stage", 16'h0, 16'(stg));
    chk("held run", 16'h1, 16'(run));
    set(4, 1'b0);
    stage_seen(1'b0, 3'h1, 1'b0);
    width = 0;
    while (stg === 3'h1 && width < 400) begin
      @(negedge clk_sys_i);
      width++;
    end
    chk("dwell length", 16'(10 * TK), 16'(width));
    stage_seen(1'b0, 3'h2, 1'b1);
    wait_run(1'b0);
    set(0, 1'b1);
    cyc(2);
    set(1, 1'b1);
    cyc(100);
    chk("run both", 16'h0, 16'(run));
    set(0, 1'b0);
    set(1, 1'b0);
    @(posedge clk_sys_i);
    auto_mode <= 1'b1;
    set(1, 1'b1);
    cyc(40);
    chk("run no advance", 16'h0, 16'(run));
    go();
    stage_seen(1'b1, 3'h0, 1'b0);
    wait_run(1'b0);
    go();
    stage_seen(1'b1, 3'h1, 1'b1);
    set(1, 1'b0);
    cyc(8);
    chk("run after drop", 16'h0, 16'(run));
    set(1, 1'b1);
    cyc(40);
    go();
    stage_seen(1'b1, 3'h0, 1'b0);
    set(2, 1'b1);
    cyc(6);
    chk("manual", 16'h1, 16'(man));
    chk("run manual", 16'h0, 16'(run));
    @(posedge clk_sys_i);
    app_mode <= 3'h0;
    cyc(3);
    chk("manual app", 16'h0, 16'(man));
    complete_run();
  end
endmodule
